/* File: sci_pkg.sv */
// Constants, register map and state codes shared by the serial channel interval block.
// Assumes a byte-wide register port and one main clock for all logic.
package sci_pkg;
    localparam int DATA_W = 8;
    localparam int ADDR_W = 16;
    localparam int FIFO_DEPTH = 8;
    localparam int CLK_PERIOD_NS = 8;
    localparam logic [ADDR_W-1:0] ADDR_MODE = 16'hFF68;
    localparam logic [ADDR_W-1:0] ADDR_INTERVAL = 16'hFF6B;
    localparam logic [ADDR_W-1:0] ADDR_SHIFT = 16'hFF6C;
    localparam logic [DATA_W-1:0] MODE_RESET = 8'h00;
    localparam logic [DATA_W-1:0] INTERVAL_RESET = 8'h00;
    localparam logic [DATA_W-1:0] MODE_WMASK = 8'hE3;
    localparam logic [DATA_W-1:0] INTERVAL_WMASK = 8'h9F;
    localparam int MODE_EN_BIT = 7;
    localparam int MODE_DIR_BIT = 6;
    localparam int MODE_ATE_BIT = 5;
    localparam int MODE_CLK_HI_BIT = 1;
    localparam int MODE_CLK_LO_BIT = 0;
    localparam int INT_EN_BIT = 7;
    localparam int INT_CODE_HI = 4;
    localparam int GAP_CNT_W = 13;
    localparam int GAP_UNIT_CLKS = 128;
    localparam int GAP_MIN_ADD_CLKS = 56;
    localparam int GAP_MAX_ADD_CLKS = 72;
    localparam logic [1:0] GAP_MIN_SCK_RISES = 2'h2;
    localparam logic [3:0] BIT_LAST = 4'h7;
    typedef enum logic [1:0]
    {
        ST_IDLE = 2'b00,
        ST_SHIFT = 2'b01,
        ST_GAP = 2'b10
    } sci_state_t;
endpackage

/* File: sci_fifo_if.sv */
// Interface carrying the byte stream between the channel top and its transmit FIFO.
// Assumes both ends run on the same main clock.
`timescale 1ns/1ps
interface sci_fifo_if #(parameter int W = 8);
    logic [W-1:0] wdata;
    logic wvalid;
    logic wready;
    logic [W-1:0] rdata;
    logic rvalid;
    logic rready;
    // The FIFO end takes pushes and offers pops.
    modport fifo (input wdata, input wvalid, output wready,
                  output rdata, output rvalid, input rready);
    // The user end pushes bytes and drains them.
    modport user (output wdata, output wvalid, input wready,
                  input rdata, input rvalid, output rready);
endinterface

/* File: sci_fifo.sv */
// Synchronous FIFO for transmit bytes of the automatic transfer path.
// Assumes one clock and an asynchronous active low reset.
`timescale 1ns/1ps
module sci_fifo #(
    parameter int W = 8,
    parameter int DEPTH = 8
) (
    input wire logic clk_i,
    input wire logic rst_n_i,
    sci_fifo_if.fifo f
);
    localparam int PW = $clog2(DEPTH);
    localparam int CW = $clog2(DEPTH + 1);
    localparam logic [PW-1:0] PTR_LAST = PW'(DEPTH - 1);
    localparam logic [CW-1:0] CNT_FULL = CW'(DEPTH);

    typedef struct packed {
        logic [DEPTH-1:0][W-1:0] mem;
        logic [PW-1:0] wptr;
        logic [PW-1:0] rptr;
        logic [CW-1:0] cnt;
    } sci_fifo_st_t;

    sci_fifo_st_t q_ff;
    sci_fifo_st_t nxt_q;
    logic push;
    logic pop;

    // Full and empty follow the occupancy count, so both flags are exact.
    assign f.wready = (q_ff.cnt != CNT_FULL);
    assign f.rvalid = (q_ff.cnt != '0);
    assign f.rdata = q_ff.mem[q_ff.rptr];
    assign push = f.wvalid & f.wready;
    assign pop = f.rvalid & f.rready;

    // Pointers wrap at the last entry so any depth works, not only powers of two.
    always_comb
    begin
        nxt_q = q_ff;
        if (push)
        begin
            nxt_q.mem[q_ff.wptr] = f.wdata;
            nxt_q.wptr = (q_ff.wptr == PTR_LAST) ? '0 : PW'(q_ff.wptr + 1'b1);
        end
        if (pop)
        begin
            nxt_q.rptr = (q_ff.rptr == PTR_LAST) ? '0 : PW'(q_ff.rptr + 1'b1);
        end
        if (push && !pop)
        begin
            nxt_q.cnt = CW'(q_ff.cnt + 1'b1);
        end
        else if (pop && !push)
        begin
            nxt_q.cnt = CW'(q_ff.cnt - 1'b1);
        end
    end

    // State register.
    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            q_ff <= '0;
        end
        else
        begin
            q_ff <= nxt_q;
        end
    end
endmodule // sci_fifo

/* File: sci_top.sv */
// Serial channel with mode and interval registers, shifter and inter-byte gap timer.
// Assumes software writes registers through the byte port and feeds automatic
// bytes through the transmit stream; port multiplexing lives outside this block.
`timescale 1ns/1ps
module sci_top #(
    parameter int GAP_UNIT = sci_pkg::GAP_UNIT_CLKS
) (
    input wire logic CLK_I,
    input wire logic RESET_N_I,
    input wire logic [sci_pkg::ADDR_W-1:0] REG_ADDR_I,
    input wire logic REG_WR_I,
    input wire logic REG_RD_I,
    input wire logic [sci_pkg::DATA_W-1:0] REG_WDATA_I,
    output logic [sci_pkg::DATA_W-1:0] REG_RDATA_O,
    input wire logic [sci_pkg::DATA_W-1:0] TX_DATA_I,
    input wire logic TX_VALID_I,
    output logic TX_READY_O,
    output logic [sci_pkg::DATA_W-1:0] RX_DATA_O,
    output logic RX_VALID_O,
    input wire logic TMR2_CLK_I,
    input wire logic PRESC_CLK_I,
    input wire logic RX_USE_I,
    input wire logic SI_I,
    output logic SO_O,
    output logic SO_OE_O,
    input wire logic SCK_I,
    output logic SCK_O,
    output logic SCK_OE_O,
    output logic STB_O,
    output logic STB_OE_O,
    output logic SI_SERIAL_O,
    output logic BUSY_O
);
    import sci_pkg::*;

    typedef struct packed {
        logic [DATA_W-1:0] mode;
        logic [DATA_W-1:0] interval;
        logic [DATA_W-1:0] shreg;
        logic so;
        logic [3:0] bitcnt;
        sci_state_t st;
        logic armed;
        logic [GAP_CNT_W-1:0] gapcnt;
        logic [1:0] sckrise;
        logic sck_m;
        logic sck_s;
        logic si_m;
        logic si_s;
        logic sck_prev;
        logic [DATA_W-1:0] rdata;
        logic [DATA_W-1:0] rxdata;
        logic rxvalid;
        logic stb;
    } sci_top_st_t;

    sci_top_st_t q_ff;
    sci_top_st_t nxt_q;
    logic enabled;
    logic auto_mode;
    logic msb_first_n;
    logic ext_clk;
    logic sck_lvl;
    logic sck_rise;
    logic sck_fall;
    logic [GAP_CNT_W-1:0] gap_target;
    logic [DATA_W-1:0] shifted;
    logic pop_ok;

    sci_fifo_if #(.W(DATA_W)) tx_if ();

    sci_fifo #(
        .W(DATA_W),
        .DEPTH(FIFO_DEPTH)
    ) u_tx_fifo (
        .clk_i(CLK_I),
        .rst_n_i(RESET_N_I),
        .f(tx_if.fifo)
    );

    // Mode decode from the stored mode register.
    assign enabled = q_ff.mode[MODE_EN_BIT];
    assign auto_mode = q_ff.mode[MODE_ATE_BIT];
    assign msb_first_n = q_ff.mode[MODE_DIR_BIT];
    assign ext_clk = ~q_ff.mode[MODE_CLK_HI_BIT];

    // The external pin is only read after its synchroniser; internal sources
    // are already on the main clock.
    always_comb
    begin
        if (ext_clk)
        begin
            sck_lvl = q_ff.sck_s;
        end
        else if (q_ff.mode[MODE_CLK_LO_BIT])
        begin
            sck_lvl = PRESC_CLK_I;
        end
        else
        begin
            sck_lvl = TMR2_CLK_I;
        end
    end

    // Edge detection against the previous sampled level.
    assign sck_rise = sck_lvl & ~q_ff.sck_prev;
    assign sck_fall = ~sck_lvl & q_ff.sck_prev;

    // The gap target follows the live interval code, which is why the code
    // must not change while an automatic sequence runs.
    assign gap_target = GAP_CNT_W'((q_ff.interval[INT_CODE_HI:0] + 1) * GAP_UNIT
                        + GAP_MIN_ADD_CLKS);

    // Next shift register content after sampling the serial input.
    assign shifted = msb_first_n ? {q_ff.si_s, q_ff.shreg[DATA_W-1:1]}
                                 : {q_ff.shreg[DATA_W-2:0], q_ff.si_s};

    // Automatic bytes are drained only when the channel waits for one.
    assign pop_ok = enabled & auto_mode & (q_ff.st == ST_IDLE);

    // Transmit stream joins the FIFO; its ready stalls the source when full.
    assign tx_if.wdata = TX_DATA_I;
    assign tx_if.wvalid = TX_VALID_I;
    assign TX_READY_O = tx_if.wready;
    assign tx_if.rready = pop_ok;

    // Whole next-state function of the channel.
    always_comb
    begin
        nxt_q = q_ff;
        nxt_q.sck_m = SCK_I;
        nxt_q.sck_s = q_ff.sck_m;
        nxt_q.si_m = SI_I;
        nxt_q.si_s = q_ff.si_m;
        nxt_q.sck_prev = sck_lvl;
        nxt_q.rxvalid = 1'b0;
        nxt_q.stb = 1'b0;

        // Register reads are answered one clock later; unmapped reads give zero.
        if (REG_RD_I)
        begin
            case (REG_ADDR_I)
                ADDR_MODE: nxt_q.rdata = q_ff.mode;
                ADDR_INTERVAL: nxt_q.rdata = q_ff.interval;
                ADDR_SHIFT: nxt_q.rdata = q_ff.shreg;
                default: nxt_q.rdata = '0;
            endcase
        end

        // Register writes; reserved bits are forced to zero.
        if (REG_WR_I)
        begin
            case (REG_ADDR_I)
                ADDR_MODE:
                begin
                    nxt_q.mode = REG_WDATA_I & MODE_WMASK;
                end
                ADDR_INTERVAL:
                begin
                    nxt_q.interval = REG_WDATA_I & INTERVAL_WMASK;
                end
                ADDR_SHIFT:
                begin
                    // A write during a shift is ignored so the byte is not torn.
                    if (q_ff.st == ST_IDLE)
                    begin
                        nxt_q.shreg = REG_WDATA_I;
                        nxt_q.so = 1'b0;
                        if (enabled && !auto_mode)
                        begin
                            nxt_q.st = ST_SHIFT;
                            nxt_q.armed = 1'b0;
                            nxt_q.bitcnt = '0;
                        end
                    end
                end
                default:
                begin
                end
            endcase
        end

        // Stopped channel: no shifting, counter held clear. The written mode is
        // used so that a stop takes effect on the very edge that stores it.
        if (!nxt_q.mode[MODE_EN_BIT])
        begin
            nxt_q.st = ST_IDLE;
            nxt_q.bitcnt = '0;
            nxt_q.gapcnt = '0;
            nxt_q.sckrise = '0;
            nxt_q.armed = 1'b0;
        end
        else
        begin
            case (q_ff.st)
                ST_IDLE:
                begin
                    // Automatic mode takes the next byte from the FIFO.
                    if (pop_ok && tx_if.rvalid)
                    begin
                        nxt_q.shreg = tx_if.rdata;
                        nxt_q.st = ST_SHIFT;
                        nxt_q.armed = 1'b0;
                        nxt_q.bitcnt = '0;
                    end
                end
                ST_SHIFT:
                begin
                    // The first falling edge arms the byte so a half-open low
                    // phase of a free running source never counts as a bit.
                    if (sck_fall)
                    begin
                        nxt_q.armed = 1'b1;
                        nxt_q.so = msb_first_n ? q_ff.shreg[0] : q_ff.shreg[DATA_W-1];
                    end
                    if (sck_rise && q_ff.armed)
                    begin
                        nxt_q.shreg = shifted;
                        nxt_q.bitcnt = 4'(q_ff.bitcnt + 1'b1);
                        if (q_ff.bitcnt == BIT_LAST)
                        begin
                            nxt_q.rxvalid = 1'b1;
                            nxt_q.rxdata = shifted;
                            nxt_q.bitcnt = '0;
                            nxt_q.st = ST_IDLE;
                            if (auto_mode)
                            begin
                                nxt_q.stb = 1'b1;
                                if (q_ff.interval[INT_EN_BIT])
                                begin
                                    nxt_q.st = ST_GAP;
                                    nxt_q.gapcnt = '0;
                                    nxt_q.sckrise = '0;
                                end
                                else
                                begin
                                    nxt_q.st = ST_IDLE;
                                end
                            end
                        end
                    end
                end
                ST_GAP:
                begin
                    // Count main clocks and serial clock rises; both must be met.
                    if (q_ff.gapcnt != gap_target)
                    begin
                        nxt_q.gapcnt = GAP_CNT_W'(q_ff.gapcnt + 1'b1);
                    end
                    if (sck_rise && (q_ff.sckrise != GAP_MIN_SCK_RISES))
                    begin
                        nxt_q.sckrise = 2'(q_ff.sckrise + 1'b1);
                    end
                    if ((q_ff.gapcnt == gap_target) &&
                        (q_ff.sckrise == GAP_MIN_SCK_RISES))
                    begin
                        nxt_q.st = ST_IDLE;
                    end
                end
                default:
                begin
                    nxt_q.st = ST_IDLE;
                end
            endcase
        end
    end

    // State register; reset clears both control registers to zero.
    always_ff @(posedge CLK_I or negedge RESET_N_I)
    begin
        if (!RESET_N_I)
        begin
            q_ff <= '0;
        end
        else
        begin
            q_ff <= nxt_q;
        end
    end

    // Pin drive; every enable drops while stopped so the port logic owns the pins.
    assign SO_O = q_ff.so;
    assign SO_OE_O = enabled;
    assign SCK_O = ((q_ff.st == ST_SHIFT) && q_ff.armed) ? sck_lvl : 1'b1;
    assign SCK_OE_O = enabled & ~ext_clk;
    assign STB_O = q_ff.stb;
    assign STB_OE_O = enabled & auto_mode;
    assign SI_SERIAL_O = enabled & RX_USE_I;
    assign BUSY_O = (q_ff.st != ST_IDLE);
    assign REG_RDATA_O = q_ff.rdata;
    assign RX_DATA_O = q_ff.rxdata;
    assign RX_VALID_O = q_ff.rxvalid;
endmodule // sci_top

/* File: sci_top_props.sv */
// Port checker for the serial channel top.
// Keeps shadows of the mode and interval registers from the write port.
`timescale 1ns/1ps
module sci_top_props #(
    parameter int GAP_UNIT = 128
) (
    input wire logic CLK_I,
    input wire logic RESET_N_I,
    input wire logic [sci_pkg::ADDR_W-1:0] REG_ADDR_I,
    input wire logic REG_WR_I,
    input wire logic REG_RD_I,
    input wire logic [sci_pkg::DATA_W-1:0] REG_WDATA_I,
    input wire logic [sci_pkg::DATA_W-1:0] REG_RDATA_O,
    input wire logic RX_USE_I,
    input wire logic RX_VALID_O,
    input wire logic SO_OE_O,
    input wire logic SCK_O,
    input wire logic SCK_OE_O,
    input wire logic STB_O,
    input wire logic STB_OE_O,
    input wire logic SI_SERIAL_O,
    input wire logic BUSY_O
);
    import sci_pkg::*;
    logic [7:0] mode_ff;
    logic [7:0] int_ff;
    logic [15:0] gcnt_ff;
    logic armed_ff;
    logic sck_q_ff;
    logic en;
    assign en = mode_ff[MODE_EN_BIT];
    // Shadows follow writes; the gap count restarts at each strobe, which marks a byte end.
    always_ff @(posedge CLK_I or negedge RESET_N_I)
    begin
        if (!RESET_N_I)
        begin
            mode_ff <= 8'h00;
            int_ff <= 8'h00;
            gcnt_ff <= 16'h0000;
            armed_ff <= 1'h0;
            sck_q_ff <= 1'h1;
        end
        else
        begin
            if (REG_WR_I && REG_ADDR_I == ADDR_MODE) mode_ff <= REG_WDATA_I & MODE_WMASK;
            if (REG_WR_I && REG_ADDR_I == ADDR_INTERVAL) int_ff <= REG_WDATA_I & INTERVAL_WMASK;
            gcnt_ff <= STB_O ? 16'h0000 : gcnt_ff + {15'h0, ~&gcnt_ff};
            // A stop ends any pending gap, so a later byte is not timed against it.
            armed_ff <= STB_O | (armed_ff & en & ~(sck_q_ff & ~SCK_O));
            sck_q_ff <= SCK_O;
        end
    end
    default clocking cb @(posedge CLK_I); endclocking
    default disable iff (!RESET_N_I);
    a_read_interval: assert property (REG_RD_I && REG_ADDR_I == ADDR_INTERVAL |=>
        REG_RDATA_O == $past(int_ff)) else $error("interval read mismatch");
    a_stop_quiet: assert property (!en |-> !BUSY_O && !RX_VALID_O && SCK_O)
        else $error("activity while stopped");
    a_pins_released: assert property (!en |-> !SO_OE_O && !SCK_OE_O && !STB_OE_O)
        else $error("pin driven while stopped");
    a_si_port_use: assert property (SI_SERIAL_O == (en && RX_USE_I))
        else $error("serial input use wrong");
    a_sck_drive: assert property (SCK_OE_O == (en && mode_ff[MODE_CLK_HI_BIT]))
        else $error("clock drive wrong");
    a_strobe_enable: assert property (STB_OE_O == (en && mode_ff[MODE_ATE_BIT]))
        else $error("strobe enable wrong");
    a_strobe_pulse: assert property (STB_O |-> mode_ff[MODE_ATE_BIT] ##1 !STB_O)
        else $error("strobe pulse wrong");
    a_gap_busy: assert property (STB_O && int_ff[INT_EN_BIT] |=> BUSY_O [*8])
        else $error("next byte not held");
    a_gap_least: assert property (armed_ff && sck_q_ff && !SCK_O && int_ff[INT_EN_BIT] |->
        gcnt_ff >= 16'((int'(int_ff[4:0]) + 1) * GAP_UNIT + 55)) else $error("gap short");
endmodule // sci_top_props
bind sci_top sci_top_props #(.GAP_UNIT(GAP_UNIT)) u_props (.CLK_I(CLK_I),
    .RESET_N_I(RESET_N_I), .REG_ADDR_I(REG_ADDR_I), .REG_WR_I(REG_WR_I),
    .REG_RD_I(REG_RD_I), .REG_WDATA_I(REG_WDATA_I), .REG_RDATA_O(REG_RDATA_O),
    .RX_USE_I(RX_USE_I), .RX_VALID_O(RX_VALID_O), .SO_OE_O(SO_OE_O), .SCK_O(SCK_O),
    .SCK_OE_O(SCK_OE_O), .STB_O(STB_O), .STB_OE_O(STB_OE_O),
    .SI_SERIAL_O(SI_SERIAL_O), .BUSY_O(BUSY_O));

/* File: sci_periph_model.sv */
// Peripheral on the three-wire link: replies to each byte with the last one inverted.
// Assumes the channel makes the serial clock; edges are seen on the main clock.
`timescale 1ns/1ps
module sci_periph_model (
    input wire logic clk_i,
    input wire logic sck_i,
    input wire logic so_i,
    input wire logic load_i,
    input wire logic [7:0] byte_i,
    output logic si_o,
    output logic [7:0] rx_o
);
    logic sck_q = 1'h1;
    logic [7:0] sh;
    logic [7:0] acc;
    logic [2:0] cnt;
    initial si_o = 1'h1;
    // Bits move after a falling edge so they are settled well before the next rise.
    always @(posedge clk_i)
    begin
        sck_q <= sck_i;
        if (load_i)
        begin
            sh <= byte_i;
            cnt <= 3'h0;
        end
        else if (sck_q && !sck_i)
        begin
            si_o <= sh[7];
            sh <= {sh[6:0], ~sh[7]};
        end
        else if (!sck_q && sck_i)
        begin
            acc <= {acc[6:0], so_i};
            cnt <= cnt + 3'h1;
            if (cnt == 3'h7)
            begin
                rx_o <= {acc[6:0], so_i};
                sh <= ~{acc[6:0], so_i};
            end
        end
    end
endmodule // sci_periph_model

/* File: test_serial_ch1_interval_and_stop_control.sv */
// Self-checking bench for the serial channel top with its peripheral model.
// Assumes a short gap unit; the serial clocks come from bench dividers.
`timescale 1ns/1ps
module test_serial_ch1_interval_and_stop_control;
    import sci_pkg::*;
    localparam int GU = 4;
    logic clk = 1'h0, rst_n = 1'h0, wr = 1'h0, rd = 1'h0, txv = 1'h0, tmr = 1'h0;
    logic pre = 1'h0, rxu = 1'h0, ld = 1'h0, armed = 1'h0, sck_q = 1'h1;
    logic [15:0] addr = 16'h0000;
    logic [7:0] wd = 8'h00, txd = 8'h00, pb = 8'h00, rdata, rxd, prx, v;
    logic rxv, txr, si, so, sck, sck_oe, busy, sck_w;
    int failures = 0, n_checks = 0, cyc = 0, t_end = 0;
    int gaps[$];
    logic [31:0] seed = 32'h0000FB66;
    assign sck_w = sck_oe ? sck : 1'h1;
    sci_top #(.GAP_UNIT(GU)) uut (.CLK_I(clk), .RESET_N_I(rst_n), .REG_ADDR_I(addr),
        .REG_WR_I(wr), .REG_RD_I(rd), .REG_WDATA_I(wd), .REG_RDATA_O(rdata),
        .TX_DATA_I(txd), .TX_VALID_I(txv), .TX_READY_O(txr), .RX_DATA_O(rxd),
        .RX_VALID_O(rxv), .TMR2_CLK_I(tmr), .PRESC_CLK_I(pre), .RX_USE_I(rxu), .SI_I(si),
        .SO_O(so), .SO_OE_O(), .SCK_I(sck_w), .SCK_O(sck), .SCK_OE_O(sck_oe), .STB_O(),
        .STB_OE_O(), .SI_SERIAL_O(), .BUSY_O(busy));
    sci_periph_model peer (.clk_i(clk), .sck_i(sck_w), .so_i(so), .load_i(ld),
        .byte_i(pb), .si_o(si), .rx_o(prx));
    always #4 clk = ~clk;
    // Serial clocks of 16 and 64 cycles, and the gap from each byte end to the next fall.
    always @(posedge clk)
    begin
        cyc <= cyc + 1;
        if (cyc % 8 == 7) tmr <= ~tmr;
        if (cyc % 32 == 31) pre <= ~pre;
        sck_q <= sck;
        if (rxv === 1'h1)
        begin
            armed <= 1'h1;
            t_end <= cyc - 1;
        end
        else if (armed && sck_q && !sck)
        begin
            gaps.push_back(cyc - t_end);
            armed <= 1'h0;
        end
    end
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        n_checks++;
        if (seen !== exp)
        begin
            failures++;
            $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic conclude();
        $display("checks %0d failures %0d", n_checks, failures);
        if (failures == 0 && n_checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    function automatic logic [7:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed[7:0];
    endfunction
    task automatic put(input logic [15:0] a, input logic [7:0] d);
        addr <= a;
        wd <= d;
        wr <= 1'h1;
        @(posedge clk);
        wr <= 1'h0;
        @(posedge clk);
    endtask
    task automatic get(input logic [15:0] a, output logic [7:0] d);
        addr <= a;
        rd <= 1'h1;
        @(posedge clk);
        rd <= 1'h0;
        #1 d = rdata;
        @(posedge clk);
    endtask
    task automatic load(input logic [7:0] b);
        pb <= b;
        ld <= 1'h1;
        @(posedge clk);
        ld <= 1'h0;
    endtask
    // Bounded wait for a finished byte; a hang is counted and ends the run.
    task automatic wait_rx(input logic [7:0] er, input logic [7:0] es);
        int i;
        for (i = 0; i < 3000; i++)
        begin
            @(posedge clk);
            #1;
            if (rxv === 1'h1) break;
        end
        if (i == 3000)
        begin
            failures++;
            conclude();
        end
        check(rxd, er);
        check(prx, es);
        @(posedge clk);
    endtask
    task automatic xfer(input logic [7:0] mode, input bit cut);
        logic [7:0] b1;
        logic [7:0] b2;
        b1 = rnd();
        b2 = rnd();
        rxu <= b1[0];
        put(ADDR_MODE, mode);
        load(b1);
        put(ADDR_SHIFT, b2);
        if (cut)
        begin
            repeat (40) @(posedge clk);
            put(ADDR_MODE, 8'h00);
            #1 check(busy, 1'h0);
        end
        else
            wait_rx(b1, b2);
    endtask
    // Fill the buffer while stopped, then run eight bytes and judge every gap.
    task automatic run_auto(input logic [7:0] ival, input logic [7:0] mode, input int p);
        logic [7:0] q[$];
        logic [7:0] e;
        int lo, hi, n;
        put(ADDR_MODE, 8'h00);
        put(ADDR_INTERVAL, ival);
        txv <= 1'h1;
        repeat (10)
        begin
            e = rnd();
            txd <= e;
            #1 if (txr === 1'h1) q.push_back(e);
            @(posedge clk);
        end
        txv <= 1'h0;
        check(16'(q.size()), 16'(FIFO_DEPTH));
        e = rnd();
        load(e);
        put(ADDR_MODE, mode);
        for (int k = 0; k < 8; k++)
        begin
            wait_rx(e, q[k]);
            e = ~q[k];
        end
        n = (int'(ival[4:0]) + 1) * GU;
        lo = ival[7] ? n + 56 + p / 2 : 0;
        if (ival[7] && lo < 2 * p) lo = 2 * p;
        hi = ival[7] ? n + 72 + 3 * p / 2 : GU + 55;
        check(16'(gaps.size() >= 7), 16'h1);
        for (int k = gaps.size() - 7; k < gaps.size(); k++)
            check(16'(gaps[k] >= lo - 2 && gaps[k] <= hi + 2), 16'h1);
        $display("auto test done, interval %h", ival);
    endtask
    initial
    begin
        logic [15:0] ra[3];
        logic [7:0] rm[3];
        ra = '{ADDR_MODE, ADDR_INTERVAL, 16'hFF6A};
        rm = '{MODE_WMASK, INTERVAL_WMASK, 8'h00};
        repeat (4) @(posedge clk);
        rst_n <= 1'h1;
        @(posedge clk);
        for (int k = 0; k < 3; k++)
        begin
            get(ra[k], v);
            check(v, 8'h00);
            put(ra[k], 8'hFF);
            get(ra[k], v);
            check(v, rm[k]);
        end
        put(ADDR_MODE, 8'h00);
        put(ADDR_INTERVAL, 8'h00);
        $display("register test done");
        put(ADDR_SHIFT, 8'h5A);
        repeat (20) @(posedge clk);
        #1 check(busy, 1'h0);
        get(ADDR_SHIFT, v);
        check(v, 8'h5A);
        $display("stop test done");
        xfer(8'h82, 1'b0);
        xfer(8'h83, 1'b0);
        xfer(8'h82, 1'b1);
        xfer(8'h82, 1'b0);
        $display("plain test done");
        run_auto(8'h00, 8'hA2, 16);
        run_auto(8'h80, 8'hA3, 64);
        run_auto(8'h9F, 8'hA2, 16);
        conclude();
    end
endmodule // test_serial_ch1_interval_and_stop_control
